// File: hdl/gplc_top.sv
// Pin C and D configuration registers and leakage compensation control
`timescale 1ns/10ps
`include "gplc_defs.svh"
module gplc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access from host interface
  input wire gplc_pkg::gplc_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Pins C (index 0) and D (index 1)
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [1:0] pin_ie,
  output logic [1:0] weak_pulldown_enable,
  // Digital output transistor drive from pin C
  output logic dout_fet_drive,
  output logic dout_fet_sel,
  // Leakage compensation enables
  output logic source_leak_comp_enable,
  output logic sink_leak_comp_enable
);
  import gplc_pkg::*;

  logic [15:0] pin_cfg_q [2];
  logic [15:0] leak_q;
  logic [1:0] pin_input_level;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic rvalid_q;
  gplc_pad_t pad [2];

  wire hit_c = req.addr == `GPLC_ADDR_PIN_C;
  wire hit_d = req.addr == `GPLC_ADDR_PIN_D;
  wire hit_l = req.addr == `GPLC_ADDR_LEAK;
  wire [1:0] hit_pin = {hit_d, hit_c};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      logic [2:0] sel;
      logic drive_out;
      logic a1_q, a2_q, a3_q;
      logic lvl_q;
      assign sel = pin_cfg_q[g][`GPLC_SEL_HI:0];
      // Output-capable modes; 011, 100 on either pin and reserved stay off
      assign drive_out = (sel == `GPLC_SEL_OUT) || (sel == `GPLC_SEL_OUTIN);
      assign pad[g].oe = drive_out;
      assign pad[g].out = drive_out & pin_cfg_q[g][`GPLC_BIT_OUT];
      assign pad[g].ie = (sel == `GPLC_SEL_OUTIN) || (sel == `GPLC_SEL_IN);
      assign pad[g].pd = pin_cfg_q[g][`GPLC_BIT_PD];
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pin_cfg_q[g] <= `GPLC_PIN_RST;
        end else if (req.wr && hit_pin[g]) begin
          pin_cfg_q[g] <= req.wdata & `GPLC_PIN_WMASK;
        end
      end
      // Three-stage pin sampler; level changes when stages two and three agree
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          a1_q <= 1'b0;
          a2_q <= 1'b0;
          a3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          a1_q <= pin_in[g];
          a2_q <= a1_q;
          a3_q <= a2_q;
          if (a2_q == a3_q) begin
            lvl_q <= a3_q;
          end
        end
      end
      assign pin_input_level[g] = lvl_q;
      assign pin_out[g] = pad[g].out;
      assign pin_oe[g] = pad[g].oe;
      assign pin_ie[g] = pad[g].ie;
      assign weak_pulldown_enable[g] = pad[g].pd;
    end
  endgenerate

  // Pin C code 100 hands the pin level to the output transistor
  assign dout_fet_sel = pin_cfg_q[0][`GPLC_SEL_HI:0] == `GPLC_SEL_FET;
  assign dout_fet_drive = dout_fet_sel & pin_input_level[0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      leak_q <= `GPLC_LEAK_RST;
    end else if (req.wr && hit_l) begin
      leak_q <= req.wdata & `GPLC_LEAK_WMASK;
    end
  end
  // Software keeps digital output modes disabled while these are set
  assign source_leak_comp_enable = leak_q[`GPLC_BIT_SRC];
  assign sink_leak_comp_enable = leak_q[`GPLC_BIT_SNK];

  // Read mux; unmapped addresses read zero
  wire [15:0] rd_c = {10'h000, pin_input_level[0], pin_cfg_q[0][4:0]};
  wire [15:0] rd_d = {10'h000, pin_input_level[1], pin_cfg_q[1][4:0]};
  assign rdata_d = hit_c ? rd_c : hit_d ? rd_d : hit_l ? leak_q : 16'h0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;

  a_reset_pins: assert property (
    @(posedge mclk)
    $fell(rst) |-> pin_cfg_q[0] == 16'h0008 && pin_cfg_q[1] == 16'h0008
    && leak_q == 16'h0000)
    else $error("reset values wrong");

  a_pulldown_rst: assert property (
    @(posedge mclk)
    $fell(rst)
    |-> weak_pulldown_enable == 2'b11)
    else $error("pull-down not on after reset");

  a_out_drive: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_c && req.wdata[2:0] == 3'h1
    |=> pin_oe[0] && pin_out[0] == $past(req.wdata[4]) && !pin_ie[0])
    else $error("code 001 drive wrong");

  a_outin_mode: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_d && req.wdata[2:0] == 3'h2
    |=> pin_oe[1] && pin_ie[1])
    else $error("code 010 enables wrong");

  a_input_mode: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_c && req.wdata[2:0] == 3'h3
    |=> !pin_oe[0] && pin_ie[0])
    else $error("code 011 wrong");

  a_hiz_codes: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_d && (req.wdata[2:0] == 3'h0 || req.wdata[2] == 1'b1)
    |=> !pin_oe[1] && !pin_ie[1])
    else $error("high impedance code drives");

  a_fet_route: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_c && req.wdata[2:0] == 3'h4
    |=> dout_fet_sel && !pin_oe[0])
    else $error("pin C transistor route wrong");

  a_input_level: assert property (
    @(posedge mclk) disable iff (rst)
    pin_in[0] [*5]
    |-> pin_input_level[0])
    else $error("input level not followed");

  a_read_resv: assert property (
    @(posedge mclk) disable iff (rst)
    req.rd
    |=> rvalid && rdata[15:6] == 10'h000)
    else $error("reserved bits not zero");

  a_leak_write: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_l
    |=> source_leak_comp_enable == $past(req.wdata[1]))
    else $error("source enable wrong");

  a_leak_sink: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_l
    |=> sink_leak_comp_enable == $past(req.wdata[0]))
    else $error("sink enable wrong");

  a_c_hiz_zero: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_c && req.wdata[2:0] == 3'h0
    |=> !pin_oe[0] && !pin_ie[0] && !dout_fet_sel)
    else $error("code 000 on pin C drives");

  a_d_out_drive: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_d && req.wdata[2:0] == 3'h1
    |=> pin_oe[1] && !pin_ie[1] && pin_out[1] == $past(req.wdata[4]))
    else $error("code 001 on pin D wrong");

  a_c_outin_mode: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_c && req.wdata[2:0] == 3'h2
    |=> pin_oe[0] && pin_ie[0] && pin_out[0] == $past(req.wdata[4]))
    else $error("code 010 on pin C wrong");

  a_d_input_mode: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_d && req.wdata[2:0] == 3'h3
    |=> !pin_oe[1] && pin_ie[1])
    else $error("code 011 on pin D wrong");

  a_c_resv_codes: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_c && req.wdata[2] && req.wdata[1:0] != 2'b00
    |=> !pin_oe[0] && !pin_ie[0] && !dout_fet_sel)
    else $error("reserved code on pin C drives");

  a_d_fet_code: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_d && req.wdata[2:0] == 3'h4
    |=> !pin_oe[1] && !pin_ie[1])
    else $error("code 100 on pin D drives");

  a_pd_write_c: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_c
    |=> weak_pulldown_enable[0] == $past(req.wdata[3]))
    else $error("pin C pull-down wrong");

  a_pd_write_d: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_d
    |=> weak_pulldown_enable[1] == $past(req.wdata[3]))
    else $error("pin D pull-down wrong");

  a_level_c: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_c
    |=> pin_out[0] == ($past(req.wdata[4]) && pin_oe[0]))
    else $error("pin C level wrong");

  a_level_d: assert property (
    @(posedge mclk) disable iff (rst)
    req.wr && hit_d
    |=> pin_out[1] == ($past(req.wdata[4]) && pin_oe[1]))
    else $error("pin D level wrong");

  a_out_gated_c: assert property (
    @(posedge mclk) disable iff (rst)
    !pin_oe[0]
    |-> !pin_out[0])
    else $error("pin C level without driver");

  a_out_gated_d: assert property (
    @(posedge mclk) disable iff (rst)
    !pin_oe[1]
    |-> !pin_out[1])
    else $error("pin D level without driver");

  a_fet_pin_c: assert property (
    @(posedge mclk) disable iff (rst)
    (dout_fet_sel && pin_in[0]) [*5]
    |-> dout_fet_drive)
    else $error("transistor not driven from pin C");

  a_fet_no_pad: assert property (
    @(posedge mclk) disable iff (rst)
    dout_fet_sel
    |-> !pin_oe[0] && !pin_ie[0])
    else $error("pin C pad active in transistor mode");

  a_leak_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !(req.wr && hit_l)
    |=> $stable(leak_q))
    else $error("leakage register changed");

  a_hold_pin_c: assert property (
    @(posedge mclk) disable iff (rst)
    !(req.wr && hit_c)
    |=> $stable(pin_cfg_q[0]))
    else $error("pin C register changed");

  a_hold_pin_d: assert property (
    @(posedge mclk) disable iff (rst)
    !(req.wr && hit_d)
    |=> $stable(pin_cfg_q[1]))
    else $error("pin D register changed");

  a_read_pin_c: assert property (
    @(posedge mclk) disable iff (rst)
    req.rd && hit_c
    |=> rdata == {10'h000, $past(pin_input_level[0]), $past(pin_cfg_q[0][4:0])})
    else $error("pin C read wrong");

  a_read_pin_d: assert property (
    @(posedge mclk) disable iff (rst)
    req.rd && hit_d
    |=> rdata == {10'h000, $past(pin_input_level[1]), $past(pin_cfg_q[1][4:0])})
    else $error("pin D read wrong");

  a_read_leak: assert property (
    @(posedge mclk) disable iff (rst)
    req.rd && hit_l
    |=> rdata == $past(leak_q))
    else $error("leakage read wrong");

  a_read_unmap: assert property (
    @(posedge mclk) disable iff (rst)
    req.rd && !hit_c && !hit_d && !hit_l
    |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_rvalid_pulse: assert property (
    @(posedge mclk) disable iff (rst)
    !req.rd
    |=> !rvalid)
    else $error("read valid without read");

  a_rdata_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !req.rd
    |=> $stable(rdata))
    else $error("read data changed without read");

  a_rst_outputs: assert property (
    @(posedge mclk)
    $fell(rst) |-> pin_oe == 2'b00 && pin_ie == 2'b00 && pin_out == 2'b00
    && !rvalid && rdata == 16'h0000)
    else $error("outputs wrong after reset");

  a_rst_leak_out: assert property (
    @(posedge mclk)
    $fell(rst)
    |-> !source_leak_comp_enable && !sink_leak_comp_enable)
    else $error("compensation on after reset");
endmodule

// File: inc/gplc_defs.svh
// Register offsets, field positions, reset values for the pin and leakage block
`ifndef GPLC_DEFS_SVH
`define GPLC_DEFS_SVH
`define GPLC_ADDR_W 8
`define GPLC_DATA_W 16
`define GPLC_ADDR_PIN_C 8'h37
`define GPLC_ADDR_PIN_D 8'h38
`define GPLC_ADDR_LEAK 8'h39
`define GPLC_BIT_IN 5
`define GPLC_BIT_OUT 4
`define GPLC_BIT_PD 3
`define GPLC_SEL_HI 2
`define GPLC_BIT_SRC 1
`define GPLC_BIT_SNK 0
`define GPLC_PIN_RST 16'h0008
`define GPLC_LEAK_RST 16'h0000
`define GPLC_PIN_WMASK 16'h001f
`define GPLC_LEAK_WMASK 16'h0003
`define GPLC_SEL_HIZ 3'h0
`define GPLC_SEL_OUT 3'h1
`define GPLC_SEL_OUTIN 3'h2
`define GPLC_SEL_IN 3'h3
`define GPLC_SEL_FET 3'h4
`endif

// File: inc/gplc_pkg.sv
// Types for the pin configuration and leakage block
package gplc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } gplc_req_t;
  typedef struct packed {
    logic out;
    logic oe;
    logic ie;
    logic pd;
  } gplc_pad_t;
endpackage

// File: verif/gplc_board.sv
// Board-side model of the two pins
`timescale 1ns/10ps
module gplc_board (
  // Pad controls from the block
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] pull_dn,
  // Board drive
  input wire logic [1:0] ext_oe,
  input wire logic [1:0] ext_val,
  // Resolved level
  output logic [1:0] level
);
  // Floating pin without pull-down reads high
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      level[i] = pin_oe[i] ? pin_out[i] : ext_oe[i] ? ext_val[i] : ~pull_dn[i];
    end
  end
endmodule

// File: verif/test_gplc_top.sv
// Self-checking bench for the pin and leakage block
`timescale 1ns/10ps
module test_gplc_top;
  import gplc_pkg::*;
  logic mclk = 0;
  logic rst = 1;
  gplc_req_t req = '0;
  logic [15:0] rdata;
  logic rvalid, fet_drv, fet_sel, src_en, snk_en;
  logic [1:0] pin_in, pin_out, pin_oe, pin_ie, pd;
  logic [1:0] ext_oe = 0;
  logic [1:0] ext_val = 0;
  int errors = 0;
  int samples_checked = 0;
  // Per code: driver on, input on, transistor select
  logic [2:0] row [8] = '{3'h0, 3'h4, 3'h6, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0};
  always #12.5 mclk = ~mclk;
  gplc_top dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_ie(pin_ie),
    .weak_pulldown_enable(pd), .dout_fet_drive(fet_drv), .dout_fet_sel(fet_sel),
    .source_leak_comp_enable(src_en), .sink_leak_comp_enable(snk_en));
  gplc_board board (.pin_out(pin_out), .pin_oe(pin_oe), .pull_dn(pd), .ext_oe(ext_oe),
    .ext_val(ext_val), .level(pin_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) req <= '{w, ~w, a, d};
    @(posedge mclk) req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(16'(rvalid), 16'h0001);
    chk(rdata, e);
  endtask
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 0;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        acc(1'b1, 8'h37 + 8'(p), 16'hffd0 | 16'(c));
        chk(16'(pin_oe[p]), 16'(row[c][2]));
        chk(16'(pin_out[p]), 16'(row[c][2]));
        chk(16'(pin_ie[p]), 16'(row[c][1]));
        chk(16'(fet_sel), 16'(row[c][0] && p == 0));
        chk(16'(pd[p]), 16'h0000);
        repeat (4) @(posedge mclk);
        rd(8'h37 + 8'(p), 16'h0030 | 16'(c));
      end
    end
    @(posedge mclk) ext_oe <= 2'b11;
    ext_val <= 2'b01;
    acc(1'b1, 8'h37, 16'h0004);
    repeat (6) @(posedge mclk);
    chk(16'(fet_drv), 16'h0001);
    acc(1'b1, 8'h38, 16'h000b);
    repeat (4) @(posedge mclk);
    rd(8'h38, 16'h000b);
    acc(1'b1, 8'h39, 16'hffff);
    chk(16'({src_en, snk_en}), 16'h0003);
    rd(8'h39, 16'h0003);
    // Output modes held off here
    acc(1'b1, 8'h39, 16'h0002);
    chk(16'({src_en, snk_en}), 16'h0002);
    rd(8'h3a, 16'h0000);
    @(posedge mclk) rst <= 1;
    ext_oe <= 2'b00;
    #1;
    chk(16'(pd), 16'h0003);
    chk(16'({pin_oe, pin_ie, src_en, snk_en, fet_drv, fet_sel}), 16'h0000);
    @(posedge mclk) rst <= 0;
    rd(8'h37, 16'h0008);
    rd(8'h38, 16'h0008);
    rd(8'h39, 16'h0000);
    wrap_up;
  end
  initial begin
    #100000;
    errors++;
    wrap_up;
  end
endmodule
